// ---- include/sst_consts.vh ----
// constants for the synchronous serial transmitter and interrupt control block
`ifndef SST_CONSTS_VH
`define SST_CONSTS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SST_OFS_RXCS     8'h00
`define SST_OFS_PARAM    8'h04
`define SST_OFS_SYNC     8'h08
`define SST_OFS_TXCS     8'h0C
`define SST_OFS_TXBUF    8'h10
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SST_RXCS_IE      6
`define SST_RXCS_DONE    7
`define SST_RXCS_MLO     8
`define SST_RXCS_MCH     15
`define SST_PAR_PAREN    12
`define SST_PAR_SYNC     13
`define SST_TXCS_MRST    0
`define SST_TXCS_SEND    4
`define SST_TXCS_FIE     5
`define SST_TXCS_IE      6
`define SST_TXCS_DONE    7
`define SST_TXCS_FILL    15
`define SST_VEC_TXBIT    2
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SST_SYNC_RST     8'hFF
`define SST_PARAM_RST    16'h0000
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SST_CLK_NS       8
`define SST_MODEM_DLY_NS 600
`define SST_LOCK_DLY_NS  20
`define SST_MODEM_CYC    ((`SST_MODEM_DLY_NS + `SST_CLK_NS - 1) / `SST_CLK_NS)
`define SST_LOCK_CYC     ((`SST_LOCK_DLY_NS + `SST_CLK_NS - 1) / `SST_CLK_NS)
`endif

// ---- core/sst_change_det.v ----
// modem control line change detector: synchroniser, delayed copy and change pulse
`timescale 1ns/100ps
module sst_change_det #(
	parameter DELAY_CYC = 75
) (
	ref_clk,
	rst,
	lineIn,
	level,
	changePulse
);
	input  wire ref_clk;     // block clock
	input  wire rst;         // internal reset, high active
	input  wire lineIn;      // raw modem line
	output wire level;       // synchronised level
	output wire changePulse; // high while level differs from delayed copy

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg        sync1_reg;    // first synchroniser stage
	reg        sync2_reg;    // second synchroniser stage
	reg        delayed_reg;  // delayed copy of the level
	reg [7:0]  dly_reg;      // delay counter

	assign level       = sync2_reg;
	assign changePulse = sync2_reg ^ delayed_reg; // [RULE4]

	// synchroniser; the delayed copy only follows after the full delay
	always @(posedge ref_clk) begin
		sync1_reg <= lineIn;
		sync2_reg <= sync1_reg;
		if (rst) begin
			delayed_reg <= 1'b0;
			dly_reg     <= 8'h00;
		end else if (changePulse) begin
			// a change holds the pulse for the whole delay; a change back before it ends drops the pulse and restarts the count
			if (dly_reg == DELAY_CYC[7:0] - 8'h01) begin
				delayed_reg <= sync2_reg; // [RULE4]
				dly_reg     <= 8'h00;
			end else begin
				dly_reg <= dly_reg + 8'h01;
			end
		end else begin
			dly_reg <= 8'h00;
		end
	end
endmodule // sst_change_det

// ---- core/sst_tx_irq_ctl.v ----
// serial transmitter, modem change detector and bus interrupt control with AHB-Lite registers
//
// Summary of operation
// (RULE1) iso start: wait clock fall, rise, load
// (RULE2) iso: empty buffer pauses with idle line
// (RULE3) five modem lines, levels shown, change flagged
// (RULE4) each line makes 600 ns change pulse
// (RULE5) status read clears modem change flag
// (RULE6) done flags request only when enabled
// (RULE7) receive served before transmit
// (RULE8) receive flag raises request and bus request
// (RULE9) grant: acknowledge, drop request, block grant
// (RULE10) grant gone, bus free: busy, interrupt, vector
// (RULE11) processor waits skew, then slave sync
// (RULE12) slave sync: lock receive, clear request
// (RULE13) pending transmit requests again after clear
// (RULE14) status read frees receive lock after 20 ns
// (RULE15) transmit vector has bit 2 set
// (RULE16) pass grant if idle or busy, no NPR
// (RULE17) sync register resets to all ones
// (RULE18) sync register is fill and match character
// (RULE19) software programs mode and sync first
// (RULE20) enable arms; first buffer write starts
// (RULE21) enable cleared: finish char, mark, idle
// (RULE22) last char gone: send fill, flag it
// (RULE23) synchronous mode sends fill when buffer empty
// (RULE24) parameter bit 13 selects synchronous mode
// (RULE25) transmit status read clears fill flag
// (RULE26) done and fill both feed transmit request
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "sst_consts.vh"
module sst_tx_irq_ctl #(
	parameter [7:0] VECTOR_BASE = 8'h30, // arbitrary vector base
	parameter       MODEM_CYC   = `SST_MODEM_CYC,
	parameter       LOCK_CYC    = `SST_LOCK_CYC
) (
	input  wire        ref_clk,
	input  wire        rstn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output reg  [31:0] hrdata,
	output wire        hresp,
	input  wire        rxDone,
	output wire [7:0]  syncChar,
	input  wire        txClk,
	output reg         serialTxOut,
	input  wire [4:0]  modemLines,
	output wire        busRequest,
	input  wire        busGrantIn,
	output wire        busGrantOut,
	output wire        busSelAck,
	input  wire        busBusyIn,
	output wire        busBusyOut,
	output wire        busBusyOe,
	output wire        busIntr,
	output reg  [7:0]  busVector,
	input  wire        busSlaveSync,
	input  wire        busNprIn,
	output wire        irq_cycle_clear
);
	// ----------------------------------------------------------------
	// state codes
	// ----------------------------------------------------------------
	localparam [1:0] TX_IDLE = 2'd0, TX_FALL = 2'd1, TX_RISE = 2'd2, TX_SHIFT = 2'd3;
	localparam [2:0] IR_IDLE = 3'd0, IR_REQ = 3'd1, IR_SACK = 3'd2, IR_BUSY = 3'd3, IR_CLR = 3'd4;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg        rst_reg;          // master reset pulse from software
	wire       rst = ~rstn | rst_reg;
	reg        rxIe_reg;         // rx_irq_enable
	reg        txIe_reg;         // tx_irq_enable
	reg        fillIe_reg;       // fill_irq_enable
	reg        send_reg;         // transmitter enable
	reg [15:0] param_reg;        // parameter_control
	reg [7:0]  sync_reg;         // shared sync and fill character
	reg [7:0]  txBuf_reg;        // tx_data_buffer
	reg        bufFull_reg;      // buffer written, not yet taken
	reg        txDone_reg;       // buffer taken by the shifter
	reg        fillSent_reg;     // fill_sent_flag
	reg        modemChg_reg;     // modem_change_flag
	reg        aValid_reg;       // captured address phase
	reg        aWrite_reg;
	reg [7:0]  aAddr_reg;

	// ----------------------------------------------------------------
	// pin synchronisers: only the second stage is read by logic
	// ----------------------------------------------------------------
	reg [4:0]  pinS1_reg;
	reg [4:0]  pinS2_reg;        // {npr, ssyn, busy, grant, txClk}
	reg        clkPrev_reg;
	always @(posedge ref_clk) begin
		pinS1_reg   <= {busNprIn, busSlaveSync, busBusyIn, busGrantIn, txClk};
		pinS2_reg   <= pinS1_reg;
		clkPrev_reg <= pinS2_reg[0];
	end
	wire clkRise  = pinS2_reg[0] & ~clkPrev_reg;
	wire clkFall  = ~pinS2_reg[0] & clkPrev_reg;
	wire grantS   = pinS2_reg[1];
	wire busyS    = pinS2_reg[2];
	wire ssynS    = pinS2_reg[3];
	wire nprS     = pinS2_reg[4];
	wire syncMode = param_reg[`SST_PAR_SYNC]; // [RULE24]

	// ----------------------------------------------------------------
	// modem change detectors
	// ----------------------------------------------------------------
	wire [4:0] modemLvl;
	wire [4:0] modemPulse;
	reg  [4:0] pulsePrev_reg;
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : gModem
			sst_change_det #(.DELAY_CYC(MODEM_CYC)) uDet (
				.ref_clk     (ref_clk),
				.rst         (rst),
				.lineIn      (modemLines[gi]),
				.level       (modemLvl[gi]),
				.changePulse (modemPulse[gi])
			); // [RULE3]
		end
	endgenerate
	wire modemSet = |(modemPulse & ~pulsePrev_reg); // [RULE3] [RULE4]

	// ----------------------------------------------------------------
	// bus slave: zero wait states, registered read data
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	wire   aTake     = hsel & hready & htrans[1];
	wire   rdRxcs    = aTake & ~hwrite & (haddr[7:0] == `SST_OFS_RXCS);
	wire   rdTxcs    = aTake & ~hwrite & (haddr[7:0] == `SST_OFS_TXCS);
	wire   wrEn      = aValid_reg & aWrite_reg;
	wire   wrTxBuf   = wrEn & (aAddr_reg == `SST_OFS_TXBUF);
	assign syncChar  = sync_reg; // [RULE18]

	// read mux: unmapped offsets read as zero
	function [31:0] readMux;
		input [7:0] a;
		begin
			case (a)
				`SST_OFS_RXCS:  readMux = {16'h0000, modemChg_reg, 2'b00, modemLvl, rxDone, rxIe_reg, 6'h00};
				`SST_OFS_PARAM: readMux = {16'h0000, param_reg};
				`SST_OFS_SYNC:  readMux = {24'h000000, sync_reg};
				`SST_OFS_TXCS:  readMux = {16'h0000, fillSent_reg, 7'h00, txDone_reg, txIe_reg, fillIe_reg,
					send_reg, 4'h0};
				`SST_OFS_TXBUF: readMux = {24'h000000, txBuf_reg};
				default:        readMux = 32'h00000000;
			endcase
		end
	endfunction

	// address capture and register writes
	always @(posedge ref_clk) begin
		if (rst) begin
			aValid_reg <= 1'b0;
			aWrite_reg <= 1'b0;
			aAddr_reg  <= 8'h00;
			hrdata     <= 32'h00000000;
			rxIe_reg   <= 1'b0;
			txIe_reg   <= 1'b0;
			fillIe_reg <= 1'b0;
			send_reg   <= 1'b0;
			param_reg  <= `SST_PARAM_RST;
			sync_reg   <= `SST_SYNC_RST; // [RULE17]
			txBuf_reg  <= 8'h00;
			rst_reg    <= 1'b0;
		end else begin
			aValid_reg <= aTake;
			aWrite_reg <= hwrite;
			aAddr_reg  <= haddr[7:0];
			rst_reg    <= 1'b0;
			if (aTake & ~hwrite)
				hrdata <= readMux(haddr[7:0]);
			if (wrEn) begin
				case (aAddr_reg)
					`SST_OFS_RXCS: rxIe_reg <= hwdata[`SST_RXCS_IE];
					`SST_OFS_PARAM: param_reg <= hwdata[15:0];
					`SST_OFS_SYNC: sync_reg <= hwdata[7:0]; // [RULE18]
					`SST_OFS_TXCS: begin
						send_reg   <= hwdata[`SST_TXCS_SEND];
						fillIe_reg <= hwdata[`SST_TXCS_FIE];
						txIe_reg   <= hwdata[`SST_TXCS_IE];
						rst_reg    <= hwdata[`SST_TXCS_MRST];
					end
					`SST_OFS_TXBUF: txBuf_reg <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// modem change flag: a new pulse wins over the read that clears it
	always @(posedge ref_clk) begin
		if (rst) begin
			pulsePrev_reg <= 5'h00;
			modemChg_reg  <= 1'b0;
		end else begin
			pulsePrev_reg <= modemPulse;
			if (modemSet)
				modemChg_reg <= 1'b1; // [RULE3]
			else if (rdRxcs)
				modemChg_reg <= 1'b0; // [RULE5]
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	reg [1:0]  txSt_reg;
	reg [10:0] shift_reg;
	reg [3:0]  bitsLeft_reg;

	// frame builder: bit 0 goes out first; returns {length, frame}
	function [14:0] buildFrame;
		input [7:0] ch;
		input       iso;
		input       parEn;
		reg         par;
		begin
			par = ~^ch;
			if (iso & parEn)
				buildFrame = {4'd11, 1'b1, par, ch, 1'b0};
			else if (iso)
				buildFrame = {4'd10, 1'b1, 1'b1, ch, 1'b0};
			else if (parEn)
				buildFrame = {4'd9, 2'b11, par, ch};
			else
				buildFrame = {4'd8, 3'b111, ch};
		end
	endfunction

	wire [14:0] frameBuf  = buildFrame(txBuf_reg, ~syncMode, param_reg[`SST_PAR_PAREN]);
	wire [14:0] frameFill = buildFrame(sync_reg, ~syncMode, param_reg[`SST_PAR_PAREN]);
	wire        takeBuf   = (txSt_reg == TX_RISE & clkRise) |
		(txSt_reg == TX_SHIFT & clkRise & bitsLeft_reg == 4'd1 & send_reg & bufFull_reg);
	wire        takeFill  = txSt_reg == TX_SHIFT & clkRise & bitsLeft_reg == 4'd1 & send_reg &
		~bufFull_reg & syncMode;

	// shifter sequence
	always @(posedge ref_clk) begin
		if (rst) begin
			txSt_reg     <= TX_IDLE;
			shift_reg    <= 11'h7FF;
			bitsLeft_reg <= 4'd0;
			serialTxOut  <= 1'b1;
		end else begin
			case (txSt_reg)
				TX_IDLE: begin
					serialTxOut <= 1'b1;
					if (send_reg & bufFull_reg)
						txSt_reg <= TX_FALL; // [RULE20]
				end
				TX_FALL: begin
					if (~send_reg)
						txSt_reg <= TX_IDLE;
					else if (clkFall)
						txSt_reg <= TX_RISE; // [RULE1]
				end
				TX_RISE: begin
					if (~send_reg)
						txSt_reg <= TX_IDLE;
					else if (clkRise) begin
						shift_reg    <= frameBuf[10:0]; // [RULE1]
						bitsLeft_reg <= frameBuf[14:11];
						serialTxOut  <= frameBuf[0];
						txSt_reg     <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (clkRise) begin
						if (bitsLeft_reg != 4'd1) begin
							shift_reg    <= {1'b1, shift_reg[10:1]};
							serialTxOut  <= shift_reg[1];
							bitsLeft_reg <= bitsLeft_reg - 4'd1;
						end else if (takeBuf) begin
							shift_reg    <= frameBuf[10:0];
							bitsLeft_reg <= frameBuf[14:11];
							serialTxOut  <= frameBuf[0];
						end else if (takeFill) begin
							shift_reg    <= frameFill[10:0]; // [RULE23] [RULE22]
							bitsLeft_reg <= frameFill[14:11];
							serialTxOut  <= frameFill[0];
						end else begin
							// iso with empty buffer pauses; cleared enable drops sync
							serialTxOut <= 1'b1; // [RULE2] [RULE21]
							txSt_reg    <= TX_IDLE;
						end
					end
				end
				default: txSt_reg <= TX_IDLE;
			endcase
		end
	end

	// buffer and transmit flags; a hardware set wins over a software clear
	always @(posedge ref_clk) begin
		if (rst) begin
			bufFull_reg  <= 1'b0;
			txDone_reg   <= 1'b0;
			fillSent_reg <= 1'b0;
		end else begin
			if (takeBuf) begin
				bufFull_reg <= wrTxBuf;
				txDone_reg  <= 1'b1; // [RULE1] [RULE22]
			end else if (wrTxBuf) begin
				bufFull_reg <= 1'b1;
				txDone_reg  <= 1'b0;
			end
			if (takeFill)
				fillSent_reg <= 1'b1; // [RULE22] [RULE25]
			else if (rdTxcs)
				fillSent_reg <= 1'b0; // [RULE25]
		end
	end

	// ----------------------------------------------------------------
	// interrupt control
	// ----------------------------------------------------------------
	reg [2:0]  irSt_reg;
	reg        lockA_reg;        // receive lockout after service
	reg        lockB_reg;        // transmit lockout after service
	reg        servTx_reg;       // cycle serves the transmit stage
	reg [3:0]  lockCnt_reg;      // delay before receive lockout lifts
	reg        lockRun_reg;
	wire reqA = rxDone & rxIe_reg & ~lockA_reg; // [RULE6] [RULE8]
	wire reqB = ((txDone_reg & txIe_reg) | (fillSent_reg & fillIe_reg)) & ~lockB_reg; // [RULE6] [RULE26]
	wire commonIrq = (irSt_reg == IR_IDLE) ? (reqA | reqB) :
		(irSt_reg == IR_REQ | irSt_reg == IR_SACK | irSt_reg == IR_BUSY);
	wire grantPassEnable = (irSt_reg == IR_BUSY | ~commonIrq) & ~nprS; // [RULE16]

	assign busRequest      = irSt_reg == IR_REQ; // [RULE8]
	assign busSelAck       = irSt_reg == IR_SACK; // [RULE9]
	assign busGrantOut     = grantS & grantPassEnable; // [RULE9] [RULE16]
	assign busBusyOut      = 1'b0;
	assign busBusyOe       = irSt_reg == IR_BUSY; // [RULE10]
	assign busIntr         = irSt_reg == IR_BUSY; // [RULE10]
	assign irq_cycle_clear = irSt_reg == IR_CLR;

	// request, grant, vector and clear sequence
	always @(posedge ref_clk) begin
		if (rst) begin
			irSt_reg   <= IR_IDLE;
			servTx_reg <= 1'b0;
			busVector  <= 8'h00;
		end else begin
			case (irSt_reg)
				IR_IDLE: begin
					if (reqA | reqB)
						irSt_reg <= IR_REQ; // [RULE8] [RULE13]
				end
				IR_REQ: begin
					if (grantS)
						irSt_reg <= IR_SACK; // [RULE9]
				end
				IR_SACK: begin
					if (~grantS & ~busyS & ~ssynS) begin
						servTx_reg <= ~reqA; // [RULE7]
						busVector  <= VECTOR_BASE | {5'b00000, ~reqA, 2'b00}; // [RULE15]
						irSt_reg   <= IR_BUSY; // [RULE10]
					end
				end
				IR_BUSY: begin
					if (ssynS)
						irSt_reg <= IR_CLR; // [RULE12]
				end
				IR_CLR: begin
					busVector <= 8'h00;
					if (~ssynS)
						irSt_reg <= IR_IDLE; // [RULE13]
				end
				default: irSt_reg <= IR_IDLE;
			endcase
		end
	end

	// lockouts: set on slave sync, receive one lifted shortly after status read
	always @(posedge ref_clk) begin
		if (rst) begin
			lockA_reg   <= 1'b0;
			lockB_reg   <= 1'b0;
			lockCnt_reg <= 4'd0;
			lockRun_reg <= 1'b0;
		end else begin
			if (rdRxcs) begin
				lockRun_reg <= 1'b1;
				lockCnt_reg <= 4'd0;
			end else if (lockRun_reg) begin
				lockCnt_reg <= lockCnt_reg + 4'd1;
				if (lockCnt_reg == LOCK_CYC[3:0] - 4'd1)
					lockRun_reg <= 1'b0;
			end
			if (irSt_reg == IR_BUSY & ssynS & ~servTx_reg)
				lockA_reg <= 1'b1; // [RULE12]
			else if (lockRun_reg & lockCnt_reg == LOCK_CYC[3:0] - 4'd1)
				lockA_reg <= 1'b0; // [RULE14]
			if (irSt_reg == IR_BUSY & ssynS & servTx_reg)
				lockB_reg <= 1'b1;
			else if (rdTxcs | wrTxBuf)
				lockB_reg <= 1'b0;
		end
	end
endmodule // sst_tx_irq_ctl

// ---- sim/sst_tx_irq_ctl_props.sv ----
// assertions on the serial line and bus interrupt ports
`timescale 1ns/100ps
module sst_tx_irq_ctl_props #(
	parameter [7:0] VECTOR_BASE = 8'h30 // arbitrary vector base
) (
	input logic       ref_clk,
	input logic       rstn,
	input logic       txClk,
	input logic       serialTxOut,
	input logic       busRequest,
	input logic       busGrantOut,
	input logic       busSelAck,
	input logic       busBusyOe,
	input logic       busIntr,
	input logic [7:0] busVector,
	input logic       busSlaveSync,
	input logic       busNprIn
);
	// ----------------------------------------------------------------
	// link clock age: the line may only move shortly after a clock rise
	// ----------------------------------------------------------------
	logic [3:0] riseAge_reg; // cycles since last rise, saturates
	logic       clkSeen_reg; // last sampled link clock
	always_ff @(posedge ref_clk) begin
		clkSeen_reg <= txClk;
		if (!rstn)
			riseAge_reg <= 4'hF;
		else if (txClk && !clkSeen_reg)
			riseAge_reg <= 4'h0;
		else if (riseAge_reg != 4'hF)
			riseAge_reg <= riseAge_reg + 4'h1;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	property p_sel_noreq; busSelAck |-> !busRequest && !busGrantOut; endproperty
	a_sel_noreq: assert property (p_sel_noreq) else $error("ack with request or grant");
	property p_npr; busNprIn [*4] |-> !busGrantOut; endproperty
	a_npr: assert property (p_npr) else $error("grant passed during npr");
	property p_nopass; busRequest && !busBusyOe |-> !busGrantOut; endproperty
	a_nopass: assert property (p_nopass) else $error("grant passed while requesting");
	property p_intr_busy; busIntr |-> busBusyOe && !busSelAck && !busRequest; endproperty
	a_intr_busy: assert property (p_intr_busy) else $error("interrupt without busy");
	property p_vec; busIntr |-> (busVector & 8'hFB) == VECTOR_BASE; endproperty
	a_vec: assert property (p_vec) else $error("vector base wrong");
	property p_vec_hold; busIntr && $past(busIntr) |-> $stable(busVector); endproperty
	a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
	property p_ssyn; $rose(busSlaveSync) |-> ##[1:8] !busIntr; endproperty
	a_ssyn: assert property (p_ssyn) else $error("interrupt held after slave sync");
	property p_ack_end; $fell(busSelAck) |-> ##[0:1] busIntr; endproperty
	a_ack_end: assert property (p_ack_end) else $error("no interrupt after ack");
	property p_tx_edge; $changed(serialTxOut) |-> riseAge_reg <= 4'h6; endproperty
	a_tx_edge: assert property (p_tx_edge) else $error("line moved off clock rise");
endmodule // sst_tx_irq_ctl_props
bind sst_tx_irq_ctl sst_tx_irq_ctl_props #(.VECTOR_BASE(VECTOR_BASE)) u_props (
	.ref_clk(ref_clk), .rstn(rstn), .txClk(txClk), .serialTxOut(serialTxOut),
	.busRequest(busRequest), .busGrantOut(busGrantOut), .busSelAck(busSelAck),
	.busBusyOe(busBusyOe), .busIntr(busIntr), .busVector(busVector),
	.busSlaveSync(busSlaveSync), .busNprIn(busNprIn));

// ---- sim/sst_modem_model.sv ----
// modem model: transmit clock, control lines and line capture
`timescale 1ns/100ps
module sst_modem_model (
	input  logic       serialTxOut,
	output logic       txClk,
	output logic [4:0] modemLines
);
	// ----------------------------------------------------------------
	// clock stands still while idle; bits sampled mid-cell on the fall
	// ----------------------------------------------------------------
	logic        run = 1'b0;      // clock enable
	logic [15:0] shiftReg = 16'h0; // newest bit at the top
	logic        inFrame = 1'b0;  // start bit seen
	logic [3:0]  bitIdx = 4'h0;   // position in frame
	int          frames = 0;      // whole start-stop frames
	int          bitCnt = 0;      // bits sampled in all
	initial txClk = 1'b0;
	initial modemLines = 5'h00;
	// stop only at low so no half cycle is left behind
	always begin
		if (run || txClk) #62.5 txClk = ~txClk;
		else #8;
	end
	always @(negedge txClk) begin
		shiftReg <= {serialTxOut, shiftReg[15:1]};
		bitCnt <= bitCnt + 1;
		if (!inFrame && !serialTxOut) begin
			inFrame <= 1'b1;
			bitIdx <= 4'h1;
		end else if (inFrame) begin
			bitIdx <= bitIdx + 4'h1;
			if (bitIdx == 4'h9) begin
				inFrame <= 1'b0;
				frames <= frames + 1;
			end
		end
	end
	task setLines(input logic [4:0] v);
		modemLines <= v;
	endtask
	task setRun(input logic v);
		run <= v;
	endtask
endmodule // sst_modem_model

// ---- sim/sst_tx_irq_ctl_test.sv ----
// self-checking bench for the transmitter and interrupt control block
`timescale 1ns/100ps
`include "sst_consts.vh"
module sst_tx_irq_ctl_test;
	localparam [7:0] VEC = 8'h30; // arbitrary vector base
	logic        ref_clk, rstn, hsel, hwrite, hreadyout, hresp, rxDone, txClk, serialTxOut;
	logic        busRequest, busGrantIn, busGrantOut, busSelAck, busBusyOut, busBusyOe;
	logic        busIntr, busSlaveSync, busNprIn, irq_cycle_clear;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [7:0]  syncChar, busVector, d, fill;
	logic [4:0]  modemLines, lines;
	int          errors, cmp_count, cycles, seed, i, f, n;
	// ----------------------------------------------------------------
	// design, modem and clock
	// ----------------------------------------------------------------
	sst_tx_irq_ctl #(.VECTOR_BASE(VEC), .MODEM_CYC(4)) uut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rxDone(rxDone), .syncChar(syncChar),
		.txClk(txClk), .serialTxOut(serialTxOut), .modemLines(modemLines), .busRequest(busRequest),
		.busGrantIn(busGrantIn), .busGrantOut(busGrantOut), .busSelAck(busSelAck), .busBusyIn(1'b0),
		.busBusyOut(busBusyOut), .busBusyOe(busBusyOe), .busIntr(busIntr), .busVector(busVector),
		.busSlaveSync(busSlaveSync), .busNprIn(busNprIn), .irq_cycle_clear(irq_cycle_clear));
	sst_modem_model modem (.serialTxOut(serialTxOut), .txClk(txClk), .modemLines(modemLines));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// hang guard, well above the few thousand cycles the run needs
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			results();
		end
	end
	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one single AHB-Lite transfer; entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int k;
		hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++k < 50);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++k < 50);
		rd = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		xfer(1'b1, a, wd, x);
	endtask
	function automatic logic sel(input int k);
		case (k)
			0: sel = busRequest;
			1: sel = busSelAck;
			2: sel = busIntr;
			default: sel = irq_cycle_clear;
		endcase
	endfunction
	task automatic waitOn(input int k, input logic v);
		int m;
		for (m = 0; sel(k) !== v && m < 1000; m++) @(posedge ref_clk);
		chk(32'(sel(k)), 32'(v));
	endtask
	// processor side of one interrupt bus cycle
	task automatic irqCycle(input logic [7:0] ev);
		waitOn(0, 1'b1);
		busGrantIn <= 1'b1;
		waitOn(1, 1'b1);
		busGrantIn <= 1'b0;
		waitOn(2, 1'b1);
		chk(32'(busVector), 32'(ev));
		repeat (10) @(posedge ref_clk); // 80 ns skew wait before sync
		busSlaveSync <= 1'b1;
		waitOn(2, 1'b0);
		busSlaveSync <= 1'b0;
		waitOn(3, 1'b0);
	endtask
	function automatic logic hasByte(input logic [15:0] s, input logic [7:0] b);
		hasByte = 1'b0;
		for (int k = 0; k < 9; k++) if (s[k+:8] == b) hasByte = 1'b1;
	endfunction
	initial begin
		seed = 74; errors = 0; cmp_count = 0; cycles = 0; lines = 5'h00;
		rstn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hwdata = 32'h0;
		rxDone = 1'b0; busGrantIn = 1'b0; busSlaveSync = 1'b0; busNprIn = 1'b0;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		xfer(1'b0, `SST_OFS_SYNC, 32'h0, r); chk(r, 32'hFF);
		xfer(1'b0, 8'h14, 32'h0, r); chk(r, 32'h0);
		busNprIn <= 1'b1; busGrantIn <= 1'b1; repeat (6) @(posedge ref_clk);
		chk(32'(busGrantOut), 32'h0);
		busNprIn <= 1'b0; repeat (6) @(posedge ref_clk);
		chk(32'(busGrantOut), 32'h1);
		busGrantIn <= 1'b0;
		fill = $random(seed);
		wr(`SST_OFS_PARAM, 32'h0); wr(`SST_OFS_SYNC, {24'h0, fill});
		xfer(1'b0, `SST_OFS_SYNC, 32'h0, r); chk(r, {24'h0, fill});
		chk(32'(syncChar), 32'(fill));
		// each modem line toggled alone, flag then cleared by the read
		for (i = 0; i < 5; i++) begin
			lines = lines ^ (5'h01 << i);
			modem.setLines(lines);
			repeat (20) @(posedge ref_clk);
			xfer(1'b0, `SST_OFS_RXCS, 32'h0, r); chk(r & 32'h9F00, {16'h0, 3'b100, lines, 8'h0});
			xfer(1'b0, `SST_OFS_RXCS, 32'h0, r); chk(32'(r[15]), 32'h0);
		end
		// isochronous: armed but silent until the buffer is written
		modem.setRun(1'b1);
		wr(`SST_OFS_TXCS, 32'h10);
		repeat (300) @(posedge ref_clk);
		chk(modem.frames, 0);
		for (i = 0; i < 3; i++) begin
			d = $random(seed);
			f = modem.frames;
			wr(`SST_OFS_TXBUF, {24'h0, d});
			xfer(1'b0, `SST_OFS_TXCS, 32'h0, r); chk(32'(r[7]), 32'h0);
			for (n = 0; modem.frames == f && n < 3000; n++) @(posedge ref_clk);
			chk(32'(modem.shiftReg[15:6]), {22'h0, 1'b1, d, 1'b0});
		end
		repeat (400) @(posedge ref_clk);
		chk(32'(modem.shiftReg), 32'hFFFF);
		xfer(1'b0, `SST_OFS_TXCS, 32'h0, r); chk(32'(r[7]), 32'h1);
		// interrupts: masked, then receive before transmit, locks
		rxDone <= 1'b1; repeat (10) @(posedge ref_clk);
		chk(32'(busRequest), 32'h0);
		wr(`SST_OFS_RXCS, 32'h40); wr(`SST_OFS_TXCS, 32'h50);
		irqCycle(VEC);
		irqCycle(VEC | 8'h04);
		repeat (20) @(posedge ref_clk);
		chk(32'(busRequest), 32'h0);
		xfer(1'b0, `SST_OFS_RXCS, 32'h0, r);
		irqCycle(VEC);
		rxDone <= 1'b0;
		wr(`SST_OFS_RXCS, 32'h0); wr(`SST_OFS_TXCS, 32'h10);
		// send dropped mid-character: that character still finishes
		d = $random(seed); f = modem.frames;
		wr(`SST_OFS_TXBUF, {24'h0, d});
		for (n = 0; !modem.inFrame && n < 3000; n++) @(posedge ref_clk);
		wr(`SST_OFS_TXCS, 32'h0);
		for (n = 0; modem.frames == f && n < 3000; n++) @(posedge ref_clk);
		chk(32'(modem.shiftReg[15:6]), {22'h0, 1'b1, d, 1'b0});
		wr(`SST_OFS_TXBUF, 32'h55); repeat (400) @(posedge ref_clk);
		chk(modem.frames, f + 1); chk(32'(modem.shiftReg), 32'hFFFF);
		// synchronous: last character followed by fill and its request
		wr(`SST_OFS_PARAM, 32'h2000); wr(`SST_OFS_TXCS, 32'h30);
		d = $random(seed); wr(`SST_OFS_TXBUF, {24'h0, d});
		irqCycle(VEC | 8'h04);
		xfer(1'b0, `SST_OFS_TXCS, 32'h0, r); chk(r & 32'h8080, 32'h8080);
		xfer(1'b0, `SST_OFS_TXCS, 32'h0, r); chk(32'(r[15]), 32'h0);
		irqCycle(VEC | 8'h04);
		wr(`SST_OFS_TXCS, 32'h10); f = modem.bitCnt;
		for (n = 0; modem.bitCnt < f + 17 && n < 3000; n++) @(posedge ref_clk);
		chk(32'(hasByte(modem.shiftReg, fill)), 32'h1);
		wr(`SST_OFS_TXCS, 32'h0); repeat (400) @(posedge ref_clk);
		modem.setRun(1'b0);
		wr(`SST_OFS_TXCS, 32'h1); repeat (4) @(posedge ref_clk);
		xfer(1'b0, `SST_OFS_SYNC, 32'h0, r); chk(r, 32'hFF);
		results();
	end
endmodule // sst_tx_irq_ctl_test
